/* File: bench/conv_model.sv */
// converter model: offers one sample per channel while that channel's phase is on
// assumes phase levels come from the sequencer on the same clock
`timescale 1ns/1ns
module conv_model #(
  parameter int NCH = 2
) (
  input  wire logic [NCH-1:0]    drop_phase_i,
  input  wire logic [NCH-1:0]    supply_phase_i,
  input  wire logic [NCH*12-1:0] drop_val_i,
  input  wire logic [NCH*11-1:0] supply_val_i,
  output logic      [NCH*12-1:0] drop_o,
  output logic      [NCH*11-1:0] supply_o
);
  // outside its phase a line shows the inverse, so a capture at the wrong time shows up
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      drop_o[c*12+:12] = drop_phase_i[c] ? drop_val_i[c*12+:12] : ~drop_val_i[c*12+:12];
      supply_o[c*11+:11] = supply_phase_i[c] ? supply_val_i[c*11+:11] : ~supply_val_i[c*11+:11];
    end
  end
endmodule

/* File: bench/power_monitor_conversion_sequencer_bench.sv */
// bench for the conversion sequencer: AXI4-Lite tasks and scenario calls
// assumes sample base of 4 cycles and rate period of 200 cycles
`timescale 1ns/1ns
`include "mon_cfg.svh"
module power_monitor_conversion_sequencer_bench;
  logic        clk;
  logic        rst_b;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic [31:0] wdata;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, done, alert, alert_oe;
  logic [1:0]  bresp, rresp, gresp;
  logic [31:0] rdata, got;
  logic [23:0] drop_val, drop_s;
  logic [21:0] sup_val, sup_s;
  logic [1:0]  dphase, sphase;
  logic [3:0]  full_scale_range;
  int          failures, tests_run, gap_n;
  int          lo[4] = '{200, 100, 73, 73};
  int          hi[4] = '{200, 100, 76, 76};

  // 50 MHz clock
  always #10 clk = ~clk;

  power_monitor_conversion_sequencer #(.NCH(2), .SAMPLE_BASE_CYC(4), .RATE_PERIOD_CYC(200)) u_dut (
    .CLOCK_I(clk), .RST_B_I(rst_b), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
    .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hf), .WVALID_I(wvalid),
    .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
    .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .DROP_SAMPLE_I(drop_s),
    .SUPPLY_SAMPLE_I(sup_s), .DROP_PHASE_O(dphase), .SUPPLY_PHASE_O(sphase),
    .FULL_SCALE_RANGE_O(full_scale_range), .CONVERSION_COMPLETE_FLAG_O(done), .ALERT_O(alert),
    .ALERT_OE_O(alert_oe));

  conv_model #(.NCH(2)) u_conv (.drop_phase_i(dphase), .supply_phase_i(sphase),
    .drop_val_i(drop_val), .supply_val_i(sup_val), .drop_o(drop_s), .supply_o(sup_s));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic timeout();
    failures++;
    $display("[ERR] %0t wait ran out", $time);
    report_and_stop();
  endtask

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) timeout();
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) timeout();
    got = rdata;
    gresp = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    check(got, e);
  endtask

  // clears the high status register (done flag) by reading it, then waits for the next cycle end
  task automatic wait_end();
    int n;
    rd(8'h0c);
    for (n = 0; n < 600; n++) begin
      @(posedge clk);
      if (done === 1'b1) break;
    end
    if (n == 600) timeout();
  endtask

  // spacing in cycles between two cycle starts of channel 0
  task automatic gap();
    int n;
    logic p;
    p = dphase[0];
    gap_n = -1;
    for (n = 0; n < 2000; n++) begin
      @(posedge clk);
      if (dphase[0] && !p && gap_n >= 0) break;
      if (dphase[0] && !p) gap_n = 0;
      if (gap_n >= 0) gap_n++;
      p = dphase[0];
    end
    if (n == 2000) timeout();
  endtask

  // number of cycle starts seen over a stretch of cycles
  task automatic quiet(input int cycles);
    logic p;
    p = dphase[0];
    gap_n = 0;
    repeat (cycles) begin
      @(posedge clk);
      if (dphase[0] && !p) gap_n++;
      p = dphase[0];
    end
  endtask

  // main sequence; the first cycle starts right after reset release
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    failures = 0;
    tests_run = 0;
    drop_val = {12'hf00, 12'h100};
    sup_val = {11'h100, 11'h200};
    repeat (8) @(posedge clk);
    check(full_scale_range, 4'hf);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc(8'h00, 32'h0f);
    rdc(8'h20, 32'h5c24);
    rdc(8'h40, 32'h5c24);
    rdc(8'h14, 32'h0);
    check(gresp, `RESP_SLVERR);
    wait_end();
    repeat (2) @(posedge clk);
    rdc(8'h0c, 32'h80);
    rdc(8'h10, 32'h0);
    rdc(8'h24, 32'h100);
    rdc(8'h28, 32'h200);
    rdc(8'h2c, 32'h800);
    rdc(8'h44, 32'hffffff00);
    rdc(8'h4c, 32'h400);
    // out-of-limit drop on channel 0 and low supply on channel 1
    wr(8'h30, 32'hff);
    wr(8'h5c, 32'h101);
    wait_end();
    wait_end();
    repeat (2) @(posedge clk);
    check(alert_oe, 1'b1);
    rdc(8'h0c, 32'h81);
    rdc(8'h10, 32'h08);
    repeat (2) @(posedge clk);
    check(alert_oe, 1'b0);
    wr(8'h00, 32'h8f);
    wait_end();
    wait_end();
    repeat (3) @(posedge clk);
    check(alert_oe, 1'b0);
    rdc(8'h0c, 32'h81);
    wr(8'h30, 32'h7ff);
    wr(8'h5c, 32'h0);
    // channel 0 sense disabled while active: its result must hold
    // masked flags still latch; clear them so unmasking raises no alert
    rdc(8'h10, 32'h08);
    wr(8'h00, 32'h0e);
    drop_val[11:0] <= 12'h050;
    wait_end();
    wait_end();
    rdc(8'h24, 32'h100);
    rdc(8'h28, 32'h200);
    for (int i = 0; i < 4; i++) begin
      wr(8'h04, i);
      gap();
      gap();
      check(gap_n >= lo[i] && gap_n <= hi[i], 1);
    end
    wr(8'h04, 32'h0);
    // a long sense time on channel 1 alone forces continuous running
    wr(8'h40, 32'h5c26);
    gap();
    gap();
    check(gap_n >= 265 && gap_n <= 268, 1);
    wr(8'h40, 32'h5c24);
    wr(8'h00, 32'h0);
    repeat (100) @(posedge clk);
    quiet(300);
    check(gap_n, 0);
    rdc(8'h00, 32'h0);
    rd(8'h0c);
    wr(8'h08, 32'h1);
    wait_end();
    repeat (2) @(posedge clk);
    rdc(8'h24, 32'h50);
    rdc(8'h08, 32'h0);
    quiet(300);
    check(gap_n, 0);
    // two-sample average at six magnitude bits: (0x0f8 + 0x050) / 2, low five bits cut
    wr(8'h20, 32'h0c2c);
    drop_val[11:0] <= 12'h0f8;
    wr(8'h08, 32'h1);
    wait_end();
    repeat (2) @(posedge clk);
    rdc(8'h24, 32'ha0);
    wr(8'h00, 32'h0f);
    wr(8'h08, 32'h1);
    rdc(8'h08, 32'h0);
    // second reset mid-run brings the settings back
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc(8'h00, 32'h0f);
    rdc(8'h04, 32'h0);
    report_and_stop();
  end
endmodule

/* File: bench/power_monitor_conversion_sequencer_properties.sv */
// concurrent checks on the sequencer's phase, status, alert and read-port behaviour
// assumes it is bound to power_monitor_conversion_sequencer and sees only its ports
`timescale 1ns/1ns
module power_monitor_conversion_sequencer_checker #(
  parameter int NCH = 2
) (
  input wire logic           CLOCK_I,
  input wire logic           RST_B_I,
  input wire logic           ARVALID_I,
  input wire logic           ARREADY_O,
  input wire logic           RVALID_O,
  input wire logic [1:0]     RRESP_O,
  input wire logic [NCH-1:0] DROP_PHASE_O,
  input wire logic [NCH-1:0] SUPPLY_PHASE_O,
  input wire logic           CONVERSION_COMPLETE_FLAG_O,
  input wire logic           ALERT_O,
  input wire logic           ALERT_OE_O
);
  // one clock domain, so clocking and reset are given once
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_B_I);

  // every channel opens its sense phase on the same edge
  chk_phase_together: assert property ($rose(DROP_PHASE_O[0]) |-> &DROP_PHASE_O)
    else $error("channels did not start together");
  // supply phase only ever follows a sense phase
  chk_sense_first: assert property ($rose(SUPPLY_PHASE_O[0]) |-> $past(DROP_PHASE_O[0]))
    else $error("supply phase without preceding sense phase");
  chk_phase_excl: assert property (!(DROP_PHASE_O[0] && SUPPLY_PHASE_O[0]))
    else $error("sense and supply phases overlap");
  chk_supply_next: assert property ($fell(DROP_PHASE_O[0]) |-> SUPPLY_PHASE_O[0])
    else $error("supply phase did not follow sense phase");
  // the shortest sample time is one sample base, four clock cycles at the bench's setting
  chk_sense_min: assert property ($rose(DROP_PHASE_O[0]) |-> DROP_PHASE_O[0] [*4])
    else $error("sense phase shorter than one sample time");
  // completion only lands right after a supply phase ends
  chk_done_at_end: assert property ($rose(CONVERSION_COMPLETE_FLAG_O) |->
    ($past(SUPPLY_PHASE_O) != '0 || $past(SUPPLY_PHASE_O, 2) != '0))
    else $error("done flag without a finished cycle");
  // alert rises on the cycle-end edge that sets the done flag, or one cycle after latched flags are unmasked
  chk_alert_cause: assert property ($rose(ALERT_OE_O) |-> CONVERSION_COMPLETE_FLAG_O)
    else $error("alert rose outside a cycle end");
  chk_alert_drain: assert property (ALERT_O == 1'b0)
    else $error("alert pin driven high");
  chk_read_answer: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
    else $error("read not answered in one cycle");
  chk_one_read: assert property (RVALID_O |-> !ARREADY_O)
    else $error("second read accepted while answering");

  cover property ($rose(ALERT_OE_O));
  cover property ($rose(CONVERSION_COMPLETE_FLAG_O));
  cover property (RVALID_O && RRESP_O == 2'h2);
endmodule

bind power_monitor_conversion_sequencer power_monitor_conversion_sequencer_checker #(.NCH(NCH))
  u_chk (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .ARVALID_I(ARVALID_I),
    .ARREADY_O(ARREADY_O), .RVALID_O(RVALID_O), .RRESP_O(RRESP_O),
    .DROP_PHASE_O(DROP_PHASE_O), .SUPPLY_PHASE_O(SUPPLY_PHASE_O),
    .CONVERSION_COMPLETE_FLAG_O(CONVERSION_COMPLETE_FLAG_O),
    .ALERT_O(ALERT_O), .ALERT_OE_O(ALERT_OE_O));

/* File: verilog/mon_cfg.svh */
// offsets, field positions, reset values and timing counts of the monitor
// assumes a 50 MHz core clock and a 32-bit AXI4-Lite register port
`ifndef MON_CFG_SVH
`define MON_CFG_SVH
// global registers
`define OFS_CONTROL     8'h00
`define OFS_RATE        8'h04
`define OFS_ONESHOT     8'h08
`define OFS_STAT_HIGH   8'h0c
`define OFS_STAT_LOW    8'h10
// per channel block at 8'h20 * (channel + 1)
`define OFS_CH_SAMPLE   5'h00
`define OFS_CH_DROP     5'h04
`define OFS_CH_SUPPLY   5'h08
`define OFS_CH_POWER    5'h0c
// control and status fields
`define CTL_MASK_BIT    7
`define STAT_DONE_BIT   7
// sample config fields
`define SC_DROP_TIME    0
`define SC_DROP_AVG     3
`define SC_SUP_TIME     5
`define SC_SUP_AVG      8
`define SC_FSR          10
`define SC_RES          12
// reset values
`define RST_CONTROL     8'h0f
`define RST_RATE        2'h0
`define RST_SAMPLE      15'h5c24
`define RST_DROP_HI     12'h7ff
`define RST_DROP_LO     12'h800
`define RST_SUP_HI      12'h7ff
`define RST_SUP_LO      12'h000
// bus answers
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
// timing
`define CLK_MHZ         50
`define SAMPLE_BASE_US  2500
`define RATE_PERIOD_MS  1000
`define SAMPLE_BASE_CYC (`SAMPLE_BASE_US * `CLK_MHZ)
`define RATE_PERIOD_CYC (`RATE_PERIOD_MS * 1000 * `CLK_MHZ)
`endif

/* File: verilog/mon_pkg.sv */
// types shared by the monitor sequencer
// assumes nothing beyond a SystemVerilog compiler
package mon_pkg;
  // gray along idle -> run -> wait -> run
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_WAIT = 2'b11
  } seq_e;
  typedef logic [7:0][11:0] hist_t;
endpackage

/* File: verilog/power_monitor_conversion_sequencer.sv */
// conversion sequencer, averaging, limits and alert of the current monitor
// assumes the converter samples arrive on CLOCK_I and hold steady per phase
`timescale 1ns/1ns
`include "mon_cfg.svh"

module power_monitor_conversion_sequencer
  import mon_pkg::*;
#(
  parameter int          NCH             = 2,
  parameter int unsigned SAMPLE_BASE_CYC = `SAMPLE_BASE_CYC,
  parameter int unsigned RATE_PERIOD_CYC = `RATE_PERIOD_CYC
) (
  input  wire logic              CLOCK_I,
  input  wire logic              RST_B_I,
  input  wire logic [7:0]        AWADDR_I,
  input  wire logic              AWVALID_I,
  output logic                   AWREADY_O,
  input  wire logic [31:0]       WDATA_I,
  input  wire logic [3:0]        WSTRB_I,
  input  wire logic              WVALID_I,
  output logic                   WREADY_O,
  output logic [1:0]             BRESP_O,
  output logic                   BVALID_O,
  input  wire logic              BREADY_I,
  input  wire logic [7:0]        ARADDR_I,
  input  wire logic              ARVALID_I,
  output logic                   ARREADY_O,
  output logic [31:0]            RDATA_O,
  output logic [1:0]             RRESP_O,
  output logic                   RVALID_O,
  input  wire logic              RREADY_I,
  input  wire logic [NCH*12-1:0] DROP_SAMPLE_I,
  input  wire logic [NCH*11-1:0] SUPPLY_SAMPLE_I,
  output logic [NCH-1:0]         DROP_PHASE_O,
  output logic [NCH-1:0]         SUPPLY_PHASE_O,
  output logic [NCH*2-1:0]       FULL_SCALE_RANGE_O,
  output logic                   CONVERSION_COMPLETE_FLAG_O,
  output logic                   ALERT_O,
  output logic                   ALERT_OE_O
);

  typedef struct packed {
    seq_e                      st;
    logic [31:0]               period_cnt;
    logic                      all_cycle;
    logic                      oneshot;
    logic [7:0]                ctrl;
    logic [1:0]                rate;
    logic [NCH-1:0][31:0]      cnt;
    logic [NCH-1:0]            drop_on;
    logic [NCH-1:0]            sup_on;
    logic [NCH-1:0][14:0]      samp;
    logic [NCH-1:0][11:0]      drop_res;
    logic [NCH-1:0][10:0]      sup_res;
    logic [NCH-1:0][15:0]      power;
    logic [NCH-1:0][3:0][11:0] lim;
    logic [NCH-1:0][7:0][11:0] h_drop;
    logic [NCH-1:0][7:0][11:0] h_sup;
    logic [7:0]                stat_hi;
    logic [7:0]                stat_lo;
    logic                      alert;
    logic                      alert_lvl;
    logic                      awready;
    logic                      wready;
    logic [7:0]                awaddr;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      arready;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
  } state_s;

  state_s      q;
  state_s      n;
  logic [32:0] rd;
  logic [31:0] wm;
  logic [31:0] td;
  logic [31:0] ts;
  logic [31:0] period;
  logic        standby;
  logic        override;
  logic        all_idle;
  logic        cont;
  logic        start;
  logic        take_one;
  logic        upd;
  logic [2:0]  res;
  logic [11:0] mag;
  logic [21:0] prod;
  logic [2:0]  cix;

  // register read: returns {mapped, data}
  function automatic logic [32:0] reg_rd(input logic [7:0] a);
    logic [2:0] c;
    logic [32:0] r;
    c = a[7:5] - 3'h1;
    r = {1'b0, 32'h0};
    if (a[7:5] == 3'h0) begin
      case (a)
        `OFS_CONTROL:   r = {1'b1, 24'h0, q.ctrl};
        `OFS_RATE:      r = {1'b1, 30'h0, q.rate};
        `OFS_ONESHOT:   r = {1'b1, 31'h0, q.oneshot};
        `OFS_STAT_HIGH: r = {1'b1, 24'h0, q.stat_hi};
        `OFS_STAT_LOW:  r = {1'b1, 24'h0, q.stat_lo};
        default:        r = {1'b0, 32'h0};
      endcase
    end else if (int'(a[7:5]) <= NCH && a[1:0] == 2'h0) begin
      if (a[4]) begin
        r = {1'b1, 20'h0, q.lim[c][a[3:2]]};
      end else begin
        case (a[4:0])
          `OFS_CH_SAMPLE: r = {1'b1, 17'h0, q.samp[c]};
          `OFS_CH_DROP:   r = {1'b1, {20{q.drop_res[c][11]}}, q.drop_res[c]};
          `OFS_CH_SUPPLY: r = {1'b1, 21'h0, q.sup_res[c]};
          default:        r = {1'b1, 16'h0, q.power[c]};
        endcase
      end
    end
    return r;
  endfunction

  // byte lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // mean of the newest 1, 2, 4 or 8 history entries
  function automatic logic [11:0] avg(input hist_t h, input logic [1:0] a,
                                      input logic sgn);
    logic [14:0] s;
    logic [14:0] r;
    s = 15'h0;
    for (int i = 0; i < 8; i++) begin
      if (i < (1 << a)) begin
        s = s + (sgn ? {{3{h[i][11]}}, h[i]} : {3'h0, h[i]});
      end
    end
    r = sgn ? 15'($signed(s) >>> a) : (s >> a);
    return r[11:0];
  endfunction

  always_comb begin
    n        = q;
    rd       = 33'h0;
    wm       = 32'h0;
    td       = 32'h0;
    ts       = 32'h0;
    res      = 3'h0;
    mag      = 12'h0;
    prod     = 22'h0;
    upd      = 1'b0;
    cix      = q.awaddr[7:5] - 3'h1;
    take_one = 1'b0;
    // write address and data are taken independently, in either order
    if (q.awready && AWVALID_I) begin
      n.awready = 1'b0;
      n.awaddr  = AWADDR_I;
    end
    if (q.wready && WVALID_I) begin
      n.wready = 1'b0;
      n.wdata  = WDATA_I;
      n.wstrb  = WSTRB_I;
    end
    // both halves held: perform the write and answer
    if (!q.awready && !q.wready && !q.bvalid) begin
      rd       = reg_rd(q.awaddr);
      wm       = merge(rd[31:0], q.wdata, q.wstrb);
      n.bvalid = 1'b1;
      n.bresp  = rd[32] ? `RESP_OKAY : `RESP_SLVERR;
      if (q.awaddr[7:5] == 3'h0) begin
        case (q.awaddr)
          `OFS_CONTROL: n.ctrl = wm[7:0];
          `OFS_RATE:    n.rate = wm[1:0];
          `OFS_ONESHOT: take_one = wm[0];
          default:      n.ctrl = q.ctrl; // status is read-only
        endcase
      end else if (rd[32]) begin
        if (q.awaddr[4]) begin
          n.lim[cix][q.awaddr[3:2]] = wm[11:0];
        end else if (q.awaddr[4:0] == `OFS_CH_SAMPLE) begin
          n.samp[cix] = wm[14:0];
        end
      end
    end
    if (q.bvalid && BREADY_I) begin
      n.bvalid  = 1'b0;
      n.awready = 1'b1;
      n.wready  = 1'b1;
    end
    // reads answer the cycle after the address; status clears on read
    if (q.arready && ARVALID_I) begin
      rd        = reg_rd(ARADDR_I);
      n.arready = 1'b0;
      n.rvalid  = 1'b1;
      n.rdata   = rd[31:0];
      n.rresp   = rd[32] ? `RESP_OKAY : `RESP_SLVERR;
      if (ARADDR_I == `OFS_STAT_HIGH) begin
        n.stat_hi = 8'h0;
      end
      if (ARADDR_I == `OFS_STAT_LOW) begin
        n.stat_lo = 8'h0;
      end
    end
    if (q.rvalid && RREADY_I) begin
      n.rvalid  = 1'b0;
      n.arready = 1'b1;
    end

    // sequencer: cycle timing per channel, all channels start together
    standby  = (q.ctrl[2*NCH-1:0] == '0);
    period   = RATE_PERIOD_CYC >> q.rate;
    override = 1'b0;
    all_idle = 1'b1;
    for (int c = 0; c < NCH; c++) begin
      td = SAMPLE_BASE_CYC << q.samp[c][`SC_DROP_TIME +: 3];
      ts = SAMPLE_BASE_CYC << q.samp[c][`SC_SUP_TIME +: 3];
      if ({1'b0, td} + {1'b0, ts} > {1'b0, period}) begin
        override = 1'b1;
      end
      if (q.drop_on[c]) begin
        all_idle   = 1'b0;
        n.cnt[c]   = q.cnt[c] + 32'h1;
        if (q.cnt[c] >= td - 32'h1) begin
          // drop phase over: keep the sample, go on to the supply
          n.h_drop[c] = {q.h_drop[c][6:0], DROP_SAMPLE_I[c*12 +: 12]};
          n.drop_on[c] = 1'b0;
          n.sup_on[c]  = 1'b1;
          n.cnt[c]     = 32'h0;
        end
      end else if (q.sup_on[c]) begin
        all_idle = 1'b0;
        n.cnt[c] = q.cnt[c] + 32'h1;
        if (q.cnt[c] >= ts - 32'h1) begin
          n.h_sup[c]  = {q.h_sup[c][6:0], 1'b0, SUPPLY_SAMPLE_I[c*11 +: 11]};
          n.sup_on[c] = 1'b0;
        end
      end
    end
    cont  = (q.rate == 2'h3) || override;
    start = 1'b0;
    if (q.st != ST_IDLE) begin
      n.period_cnt = q.period_cnt + 32'h1;
    end
    unique case (q.st)
      ST_IDLE: begin
        // no cycles while standby without a request
        if (!standby || q.oneshot) begin
          start       = 1'b1;
          n.all_cycle = standby;
          n.st        = ST_RUN;
        end
      end
      ST_RUN: begin
        if (all_idle) begin
          // cycle end: results, then limits and status
          for (int c = 0; c < NCH; c++) begin
            upd = q.all_cycle || q.ctrl[2*c];
            if (upd) begin
              res = (q.samp[c][`SC_RES +: 3] > 3'h5) ? 3'h5 : q.samp[c][`SC_RES +: 3];
              n.drop_res[c] = avg(q.h_drop[c], q.samp[c][`SC_DROP_AVG +: 2], 1'b1)
                              & (12'hfff << (3'h5 - res));
            end
            upd = q.all_cycle || q.ctrl[2*c+1];
            if (upd) begin
              wm = {20'h0, avg(q.h_sup[c], q.samp[c][`SC_SUP_AVG +: 2], 1'b0)};
              n.sup_res[c] = wm[10:0];
            end
            // compare every new result against its limits
            if ($signed(n.drop_res[c]) > $signed(q.lim[c][0])) begin
              n.stat_hi[2*c] = 1'b1;
            end
            if ($signed(n.drop_res[c]) < $signed(q.lim[c][1])) begin
              n.stat_lo[2*c] = 1'b1;
            end
            if ({1'b0, n.sup_res[c]} > q.lim[c][2]) begin
              n.stat_hi[2*c+1] = 1'b1;
            end
            if ({1'b0, n.sup_res[c]} < q.lim[c][3]) begin
              n.stat_lo[2*c+1] = 1'b1;
            end
          end
          n.stat_hi[`STAT_DONE_BIT] = 1'b1;
          if (q.all_cycle || standby) begin
            n.oneshot = 1'b0;
            n.st      = ST_IDLE;
          end else if (cont) begin
            start = 1'b1;
          end else begin
            n.st = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (standby) begin
          n.st = ST_IDLE;
        end else if (cont || q.period_cnt >= period - 32'h1) begin
          start = 1'b1;
          n.st  = ST_RUN;
        end
      end
      default: n.st = ST_IDLE;
    endcase
    if (start) begin
      n.period_cnt = 32'h0;
      for (int c = 0; c < NCH; c++) begin
        n.cnt[c]     = 32'h0;
        n.drop_on[c] = 1'b1;
        n.sup_on[c]  = 1'b0;
      end
    end
    // request taken only in standby while idle, so a set in the clearing cycle is dropped
    if (take_one && standby && q.st == ST_IDLE) begin
      n.oneshot = 1'b1;
    end

    // power follows the stored results on every clock
    for (int c = 0; c < NCH; c++) begin
      mag = q.drop_res[c][11] ? 12'h0 - q.drop_res[c] : q.drop_res[c];
      if (mag[11]) begin
        mag = 12'h7ff; // saturate the single -full-scale code
      end
      prod       = mag[10:0] * q.sup_res[c];
      n.power[c] = prod[21:6];
    end
    // alert follows unmasked limit flags, which only set at cycle end
    n.alert = !q.ctrl[`CTL_MASK_BIT] &&
              ((n.stat_hi[2*NCH-1:0] | n.stat_lo[2*NCH-1:0]) != '0);
  end

  // one register stage for the whole state
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      q         <= '0;
      q.st      <= ST_IDLE;
      q.ctrl    <= `RST_CONTROL;
      q.rate    <= `RST_RATE;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
      for (int c = 0; c < NCH; c++) begin
        q.samp[c]   <= `RST_SAMPLE;
        q.lim[c][0] <= `RST_DROP_HI;
        q.lim[c][1] <= `RST_DROP_LO;
        q.lim[c][2] <= `RST_SUP_HI;
        q.lim[c][3] <= `RST_SUP_LO;
      end
    end else begin
      q <= n;
    end
  end

  // per channel pins straight from the state flops
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign DROP_PHASE_O[c]           = q.drop_on[c];
    assign SUPPLY_PHASE_O[c]         = q.sup_on[c];
    assign FULL_SCALE_RANGE_O[c*2 +: 2] = q.samp[c][`SC_FSR +: 2];
  end

  assign AWREADY_O                  = q.awready;
  assign WREADY_O                   = q.wready;
  assign BVALID_O                   = q.bvalid;
  assign BRESP_O                    = q.bresp;
  assign ARREADY_O                  = q.arready;
  assign RVALID_O                   = q.rvalid;
  assign RDATA_O                    = q.rdata;
  assign RRESP_O                    = q.rresp;
  assign CONVERSION_COMPLETE_FLAG_O = q.stat_hi[`STAT_DONE_BIT];
  // open drain: only ever pulls low, enable high while asserted
  assign ALERT_O                    = q.alert_lvl;
  assign ALERT_OE_O                 = q.alert;

endmodule
